// File: hdl/hub_consts.svh
// Constants of the flash hub cycle guard: field codes, offsets, timing.
// Assumes a 100 MHz clk_sys that is also the nibble bus clock.
`ifndef HUB_CONSTS_SVH
`define HUB_CONSTS_SVH
`define START_RD      4'hd
`define START_WR      4'he
`define NIB_ABORT     4'hf
`define NIB_TAR       4'hf
`define NIB_SYNC      4'h0
`define SIZE_ONE      4'h0
`define ADDR_LAST     3'h6
`define A22_NIB       3'h1
`define A22_BIT       2
`define LOCK_REG_OFS  16'h0002
`define LOCK_RESET    16'hffff
`define TOP_BLK       4'hf
`define INV_LIMIT_3M  20'h20000
`define DATA_NONE     8'h00
`define PIN_IDLE      8'hff
`define CLK_NS        10
`define RST_LAT_NS    500
`define RST_LAT_CYC   ((`RST_LAT_NS + `CLK_NS - 1) / `CLK_NS)
`define PIN_INIT      0
`define PIN_RST       1
`define PIN_TBL       2
`define PIN_WP        3
`endif

// File: hdl/hub_pkg.sv
// Types of the flash hub cycle guard: bus states and state records.
// Used with hub_consts.svh; no other dependency.
`default_nettype none
package hub_pkg;
    typedef enum logic [3:0] {
        S_IDLE, S_SEL, S_ADDR, S_SIZE, S_WLO, S_WHI, S_TAR0, S_TAR1,
        S_SYNC, S_RLO, S_RHI, S_TOUT, S_STBY, S_ABWAIT
    } bus_st_t;

    typedef struct packed {
        bus_st_t     st;
        logic [2:0]  cnt;
        logic        rd;
        logic        a22;
        logic [19:0] addr;
        logic [7:0]  data;
        logic [3:0]  out;
        logic        oe;
        logic        crd;
        logic        cwr;
        logic        prot;
        logic        abort;
        logic [5:0]  rlat;
        logic [15:0] lock;
        logic [7:0]  poll;
    } guard_st_t;

    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
        logic [7:0] s3;
        logic [7:0] val;
    } sync_st_t;

    typedef struct packed {
        logic tog;
    } poll_st_t;
endpackage
`default_nettype wire

// File: hdl/poll_if.sv
// Carrier between the cycle guard and the write status poller.
// Both ends run on clk_sys.
`default_nettype none
interface poll_if;
    logic       busy;
    logic       erasing;
    logic       prog7;
    logic       rd_take;
    logic [7:0] raw;
    logic [7:0] status;
    modport guard  (output busy, erasing, prog7, rd_take, raw,
                    input status);
    modport poller (input busy, erasing, prog7, rd_take, raw,
                    output status);
endinterface
`default_nettype wire

// File: hdl/pin_sync3.sv
// Three-stage synchroniser for the eight asynchronous pins.
// A change is taken once stages two and three agree.
`default_nettype none
`include "hub_consts.svh"
module pin_sync3 (
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       clk_en,
    input  wire logic [7:0] pins,
    output logic [7:0]      pins_s
);
    hub_pkg::sync_st_t q;
    hub_pkg::sync_st_t d;

    always_comb begin
        d = q;
        d.s1 = pins;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.val = (q.s2 & q.s3) | (q.val & (q.s2 | q.s3));
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            q <= {4{`PIN_IDLE}};
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign pins_s = q.val;
endmodule
`default_nettype wire

// File: hdl/write_status_poll.sv
// Substitutes the end-of-write status bits into flash read data.
// Expects one rd_take pulse per host read of the flash core.
`default_nettype none
module write_status_poll (
    input  wire logic clk_sys,
    input  wire logic rst_b,
    input  wire logic clk_en,
    poll_if.poller    pif
);
    hub_pkg::poll_st_t q;
    hub_pkg::poll_st_t d;

    always_comb begin
        d = q;
        if (pif.busy && pif.rd_take) begin
            d.tog = ~q.tog;
        end
        pif.status = pif.raw;
        if (pif.busy) begin
            pif.status[6] = q.tog;
            // Erase polls as zero, program as inverted data
            pif.status[7] = pif.erasing ? 1'b0 : ~pif.prog7;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            q <= '0;
        end else if (clk_en) begin
            q <= d;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    chk_toggle_flip: assert property (
        (clk_en && pif.busy && pif.rd_take) |=> q.tog != $past(q.tog))
        else $error("toggle bit did not flip on busy read");
    chk_toggle_hold: assert property (
        (clk_en && !pif.busy) |=> q.tog == $past(q.tog))
        else $error("toggle bit moved while idle");
    chk_poll_prog: assert property (
        (pif.busy && !pif.erasing) |-> pif.status[7] == ~pif.prog7)
        else $error("program poll bit not inverted");
    chk_poll_erase: assert property (
        pif.busy && pif.erasing |-> !pif.status[7] && 
        pif.status[6] == q.tog)
        else $error("erase poll bit not zero");
    chk_poll_pass: assert property (
        !pif.busy |-> pif.status == pif.raw)
        else $error("status altered while idle");
endmodule
`default_nettype wire

// File: hdl/hub_flash_cycle_guard.sv
// Front end of a nibble-bus flash hub: cycle decode, routing, locking.
// The nibble bus and frame strobe run on clk_sys; other pins are async.
// The core behind core_* reads combinationally and reports busy state.
`default_nettype none
`include "hub_consts.svh"

module hub_flash_cycle_guard #(
    parameter bit VARIANT_3M = 1'b0,
    parameter bit BOOT_16K   = 1'b0
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        clk_en,
    input  wire logic        frame_strobe_n,
    input  wire logic [3:0]  nibble_bus_in,
    output logic [3:0]       nibble_bus_out,
    output logic             nibble_bus_oe,
    input  wire logic [3:0]  strap_select_pins,
    input  wire logic        top_boot_lock_n,
    input  wire logic        write_protect_n,
    input  wire logic        init_n,
    input  wire logic        reset_pin_n,
    input  wire logic [7:0]  core_rdata,
    input  wire logic        core_busy,
    input  wire logic        core_erasing,
    output logic             core_rd_req,
    output logic             core_wr_req,
    output logic [19:0]      core_addr,
    output logic [7:0]       core_wdata,
    output logic             core_wr_protect,
    output logic             core_abort
);
    hub_pkg::guard_st_t q;
    hub_pkg::guard_st_t d;
    logic [7:0]         pins_s;
    logic               rst_any;
    logic               frame_low;
    logic               is_start;
    logic [7:0]         rd_mux;
    poll_if             pif ();

    function automatic logic in_boot(input logic [19:0] a);
        in_boot = BOOT_16K ? (a[17:14] == `TOP_BLK)
                           : (a[19:16] == `TOP_BLK);
    endfunction

    function automatic logic bad_range(input logic [19:0] a);
        bad_range = VARIANT_3M && (a < `INV_LIMIT_3M);
    endfunction

    function automatic logic protect(input logic [19:0] a,
                                     input logic [7:0]  p,
                                     input logic [15:0] lk);
        if (in_boot(a)) begin
            protect = !p[`PIN_TBL] || lk[`TOP_BLK];
        end else begin
            protect = !p[`PIN_WP] || lk[a[19:16]];
        end
    endfunction

    pin_sync3 u_sync (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .clk_en  (clk_en),
        .pins    ({strap_select_pins, write_protect_n,
                   top_boot_lock_n, reset_pin_n, init_n}),
        .pins_s  (pins_s)
    );

    write_status_poll u_poll (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .clk_en  (clk_en),
        .pif     (pif)
    );

    // Either reset pin has the same internal effect
    assign rst_any = !pins_s[`PIN_INIT] || !pins_s[`PIN_RST];
    assign frame_low = !frame_strobe_n;
    assign is_start = (nibble_bus_in == `START_RD) ||
                      (nibble_bus_in == `START_WR);

    assign pif.busy    = core_busy;
    assign pif.erasing = core_erasing;
    assign pif.prog7   = q.poll[7];
    assign pif.raw     = core_rdata;
    assign pif.rd_take = (q.st == hub_pkg::S_TAR1) && q.rd && q.a22 &&
                         !rst_any && !frame_low;

    always_comb begin
        rd_mux = `DATA_NONE;
        if (q.a22) begin
            // Status is meaningless out of range, so plain zero
            if (!bad_range(q.addr)) begin
                rd_mux = pif.status;
            end
        end else if (!core_busy && q.addr[15:0] == `LOCK_REG_OFS) begin
            rd_mux = {7'h00, q.lock[q.addr[19:16]]};
        end
        // Any other register location stays zero
    end

    always_comb begin
        d = q;
        d.crd = 1'b0;
        d.cwr = 1'b0;
        d.abort = 1'b0;
        if (q.rlat != 6'h00) begin
            d.rlat = q.rlat - 6'h01;
            d.abort = (q.rlat == 6'h01);
        end
        if (rst_any || q.rlat != 6'h00) begin
            d.st = hub_pkg::S_IDLE;
            d.oe = 1'b0;
            d.out = `NIB_TAR;
            d.lock = `LOCK_RESET;
            if (rst_any && core_busy && q.rlat == 6'h00 && !q.abort) begin
                d.rlat = 6'(`RST_LAT_CYC);
            end
        end else if (frame_low && q.st != hub_pkg::S_IDLE &&
                     q.st != hub_pkg::S_SEL && q.st != hub_pkg::S_STBY &&
                     q.st != hub_pkg::S_ABWAIT) begin
            d.st = hub_pkg::S_ABWAIT;
            d.oe = 1'b0;
        end else begin
            case (q.st)
            hub_pkg::S_IDLE, hub_pkg::S_STBY: begin
                if (frame_low && is_start) begin
                    d.st = hub_pkg::S_SEL;
                    d.rd = (nibble_bus_in == `START_RD);
                end
            end
            hub_pkg::S_SEL: begin
                // Only the last start nibble before frame rises counts
                if (frame_low) begin
                    if (is_start) begin
                        d.rd = (nibble_bus_in == `START_RD);
                    end else begin
                        d.st = hub_pkg::S_IDLE;
                    end
                end else if (nibble_bus_in == pins_s[7:4]) begin
                    d.st = hub_pkg::S_ADDR;
                    d.cnt = 3'h0;
                end else begin
                    d.st = hub_pkg::S_STBY;
                end
            end
            hub_pkg::S_ADDR: begin
                // Upper nibbles shift out; only bit 22 is kept from them
                d.addr = {q.addr[15:0], nibble_bus_in};
                if (q.cnt == `A22_NIB) begin
                    d.a22 = nibble_bus_in[`A22_BIT];
                end
                d.cnt = q.cnt + 3'h1;
                if (q.cnt == `ADDR_LAST) begin
                    d.st = hub_pkg::S_SIZE;
                end
            end
            hub_pkg::S_SIZE: begin
                if (nibble_bus_in != `SIZE_ONE) begin
                    d.st = hub_pkg::S_IDLE;
                end else if (q.rd) begin
                    d.st = hub_pkg::S_TAR0;
                    d.crd = q.a22;
                end else begin
                    d.st = hub_pkg::S_WLO;
                end
            end
            hub_pkg::S_WLO: begin
                d.data[3:0] = nibble_bus_in;
                d.st = hub_pkg::S_WHI;
            end
            hub_pkg::S_WHI: begin
                d.data[7:4] = nibble_bus_in;
                d.st = hub_pkg::S_TAR0;
            end
            hub_pkg::S_TAR0: begin
                d.st = hub_pkg::S_TAR1;
                if (!q.rd && q.a22 && !bad_range(q.addr)) begin
                    // Byte goes to the core with the protect() verdict on core_wr_protect
                    d.cwr = 1'b1;
                    d.prot = protect(q.addr, pins_s, q.lock);
                    if (!core_busy) begin
                        d.poll = q.data;
                    end
                end else if (!q.rd && !q.a22 && !core_busy &&
                             q.addr[15:0] == `LOCK_REG_OFS) begin
                    d.lock[q.addr[19:16]] = q.data[0];
                end
            end
            hub_pkg::S_TAR1: begin
                // Core has had a full cycle to answer the read
                if (q.rd) begin
                    d.data = rd_mux;
                end
                d.oe = 1'b1;
                d.out = `NIB_SYNC;
                d.st = hub_pkg::S_SYNC;
            end
            hub_pkg::S_SYNC: begin
                if (q.rd) begin
                    d.out = q.data[3:0];
                    d.st = hub_pkg::S_RLO;
                end else begin
                    d.out = `NIB_TAR;
                    d.st = hub_pkg::S_TOUT;
                end
            end
            hub_pkg::S_RLO: begin
                d.out = q.data[7:4];
                d.st = hub_pkg::S_RHI;
            end
            hub_pkg::S_RHI: begin
                d.out = `NIB_TAR;
                d.st = hub_pkg::S_TOUT;
            end
            hub_pkg::S_TOUT: begin
                d.oe = 1'b0;
                d.st = hub_pkg::S_IDLE;
            end
            hub_pkg::S_ABWAIT: begin
                if (nibble_bus_in == `NIB_ABORT) begin
                    d.st = hub_pkg::S_IDLE;
                end
            end
            default: begin
                d.st = hub_pkg::S_IDLE;
            end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            q <= '0;
            q.out <= `NIB_TAR;
            q.lock <= `LOCK_RESET;
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign nibble_bus_out  = q.out;
    assign nibble_bus_oe   = q.oe;
    assign core_rd_req     = q.crd;
    assign core_wr_req     = q.cwr;
    assign core_addr       = q.addr;
    assign core_wdata      = q.data;
    assign core_wr_protect = q.prot;
    assign core_abort      = q.abort;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    chk_size_drop: assert property (
        (clk_en && !rst_any && q.rlat == 6'h00 && frame_strobe_n &&
         q.st == hub_pkg::S_SIZE && nibble_bus_in != `SIZE_ONE)
        |=> q.st == hub_pkg::S_IDLE && !core_rd_req && !nibble_bus_oe)
        else $error("bad size field not dropped");
    chk_id_mismatch: assert property (
        (clk_en && !rst_any && q.rlat == 6'h00 && frame_strobe_n &&
         q.st == hub_pkg::S_SEL && nibble_bus_in != pins_s[7:4])
        |=> q.st == hub_pkg::S_STBY)
        else $error("select mismatch did not enter standby");
    chk_reset_float: assert property (
        (clk_en && rst_any) |=> !nibble_bus_oe && !core_wr_req)
        else $error("bus still driven under reset");
    chk_region_route: assert property (
        core_rd_req || core_wr_req |-> q.a22)
        else $error("core access with register-space address");
    chk_invalid_zero: assert property (
        (q.st == hub_pkg::S_SYNC && q.rd && q.a22 && bad_range(q.addr))
        |-> q.data == `DATA_NONE)
        else $error("invalid range read not zero");
    chk_unused_reg: assert property (
        (q.st == hub_pkg::S_SYNC && q.rd && !q.a22 &&
         q.addr[15:0] != `LOCK_REG_OFS) |-> q.data == `DATA_NONE)
        else $error("unused register read not zero");
    chk_boot_lock: assert property (
        core_wr_req && in_boot(core_addr) &&
        $past(!pins_s[`PIN_TBL]) |-> core_wr_protect)
        else $error("boot write unprotected with lock pin low");
    chk_reg_busy: assert property (
        (clk_en && core_busy && !rst_any && q.rlat == 6'h00)
        |=> q.lock == $past(q.lock))
        else $error("lock register changed while core busy");
    chk_abort_wait: assert property (
        (clk_en && !rst_any && q.rlat == 6'h00 &&
         q.st == hub_pkg::S_ABWAIT && nibble_bus_in != `NIB_ABORT)
        |=> q.st == hub_pkg::S_ABWAIT)
        else $error("left abort wait without 1111b");
    chk_rst_latency: assert property (
        (clk_en && rst_any && core_busy && q.rlat == 6'h00 && !core_abort)
        |=> !core_abort ##1 (q.rlat != 6'h00))
        else $error("reset latency not started");
    chk_abort_once: assert property (
        core_abort |=> !core_abort)
        else $error("abort pulse too long");
    chk_stby_quiet: assert property (
        q.st == hub_pkg::S_STBY |-> !nibble_bus_oe && !core_rd_req)
        else $error("standby not quiet");
    chk_abwait_quiet: assert property (
        q.st == hub_pkg::S_ABWAIT |-> !nibble_bus_oe)
        else $error("bus driven in abort wait");
    chk_wp_lock: assert property (
        core_wr_req && !in_boot(core_addr) &&
        $past(!pins_s[`PIN_WP]) |-> core_wr_protect)
        else $error("protect pin ignored");
    chk_rst_relock: assert property (
        (clk_en && rst_any) |=> q.lock == `LOCK_RESET)
        else $error("reset pin kept locks");
    chk_wr_single: assert property (
        core_wr_req |=> !core_wr_req)
        else $error("write pulse too long");

    cov_read: cover property (q.st == hub_pkg::S_RHI && q.a22);
    cov_write: cover property (core_wr_req && !core_wr_protect);
    cov_abort: cover property (q.st == hub_pkg::S_ABWAIT);
    cov_standby: cover property (q.st == hub_pkg::S_STBY);
    cov_rst_abort: cover property (core_abort);
endmodule
`default_nettype wire

// File: sim/flash_core_model.sv
// Behavioural flash core standing behind the guard's core_* ports.
// Assumes one clk_sys; the bench commands the busy and erase states.
`default_nettype none
module flash_core_model (
    input  wire logic        clk_sys,
    input  wire logic        core_rd_req,
    input  wire logic        core_wr_req,
    input  wire logic [19:0] core_addr,
    input  wire logic [7:0]  core_wdata,
    input  wire logic        core_wr_protect,
    input  wire logic        core_abort,
    input  wire logic        busy_cmd,
    input  wire logic        erase_cmd,
    output logic [7:0]       core_rdata,
    output logic             core_busy,
    output logic             core_erasing,
    output logic [7:0]       n_rd = 8'h00,
    output logic [7:0]       n_wr = 8'h00,
    output logic [7:0]       n_abort = 8'h00,
    output logic [28:0]      last_wr = 29'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic stop_q = 1'b0;
    // A fixed pattern of the address, so the bench can predict read data
    assign core_rdata   = core_addr[7:0] ^ 8'h3c;
    // An abort ends the running operation until the bench drops busy
    assign core_busy    = busy_cmd & ~stop_q;
    assign core_erasing = erase_cmd;
    always @(posedge clk_sys) begin
        if (core_rd_req) n_rd <= n_rd + 8'h01;
        if (core_wr_req) begin
            n_wr    <= n_wr + 8'h01;
            last_wr <= {core_wr_protect, core_wdata, core_addr};
        end
        if (core_abort) n_abort <= n_abort + 8'h01;
        stop_q <= core_abort | (busy_cmd & stop_q);
    end
endmodule
`default_nettype wire

// File: sim/hub_flash_cycle_guard_bench.sv
// Self-checking bench of hub_flash_cycle_guard with a core model.
// Bus has a pull-up: an idle host drives 1111; pins settle in 4 cycles, the bench waits 6.
`default_nettype none
module hub_flash_cycle_guard_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic        frame_n = 1'b1;
    logic [3:0]  nib = 4'hf;
    logic [3:0]  strap = 4'h0;
    logic        tbl_n = 1'b1;
    logic        wp_n = 1'b1;
    logic        init_n = 1'b1;
    logic        rpin_n = 1'b1;
    logic        busy_cmd = 1'b0;
    logic        erase_cmd = 1'b0;
    logic [3:0]  bus_out;
    logic        bus_oe, busy, erasing, rd_req, wr_req, prot, abort;
    logic [7:0]  rdata, wdata, n_rd, n_wr, n_abort;
    logic [19:0] caddr;
    logic [28:0] last_wr;
    int          n_fail = 0;
    int          n_checks = 0;
    int          cyc = 0;

    always #5 clk_sys = ~clk_sys;

    hub_flash_cycle_guard #(.VARIANT_3M(1'b1)) i_hub_flash_cycle_guard (
        .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(1'b1),
        .frame_strobe_n(frame_n), .nibble_bus_in(nib),
        .nibble_bus_out(bus_out), .nibble_bus_oe(bus_oe),
        .strap_select_pins(strap), .top_boot_lock_n(tbl_n),
        .write_protect_n(wp_n), .init_n(init_n), .reset_pin_n(rpin_n),
        .core_rdata(rdata), .core_busy(busy), .core_erasing(erasing),
        .core_rd_req(rd_req), .core_wr_req(wr_req), .core_addr(caddr),
        .core_wdata(wdata), .core_wr_protect(prot), .core_abort(abort));

    flash_core_model i_flash_core_model (
        .clk_sys(clk_sys), .core_rd_req(rd_req), .core_wr_req(wr_req),
        .core_addr(caddr), .core_wdata(wdata), .core_wr_protect(prot),
        .core_abort(abort), .busy_cmd(busy_cmd), .erase_cmd(erase_cmd),
        .core_rdata(rdata), .core_busy(busy), .core_erasing(erasing),
        .n_rd(n_rd), .n_wr(n_wr), .n_abort(n_abort), .last_wr(last_wr));

    task automatic print_verdict();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            $display("[FAIL] %0t timeout", $time);
            print_verdict();
        end
    end

    task automatic chk(input bit ok, input string msg);
        n_checks++;
        if (!ok) begin
            n_fail++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic settle();
        repeat (6) @(negedge clk_sys);
    endtask

    // One host cycle; brk drops the frame mid-cycle, rs pulls init_n low
    task automatic cyc_run(input logic [3:0] st, sel, input logic [27:0] a,
        input logic [3:0] sz, input logic [7:0] wd, input int brk, rs,
        output logic [15:0] rsp, output int f);
        int k;
        k = 0;
        f = -1;
        rsp = 16'hxxxx;
        for (int i = 0; i < 20; i++) begin
            @(negedge clk_sys);
            if (bus_oe === 1'b1) begin
                if (f < 0) f = i;
                if (k < 4) rsp[15-4*k -: 4] = bus_out;
                k++;
            end
            frame_n = !(i == 0 || i == brk);
            if (i == rs) init_n = 1'b0;
            case (i)
                0: nib = st;
                1: nib = sel;
                2, 3, 4, 5, 6, 7, 8: nib = a[4*(8-i) +: 4];
                9: nib = sz;
                10: nib = (st == 4'he) ? wd[3:0] : 4'hf;
                11: nib = (st == 4'he) ? wd[7:4] : 4'hf;
                default: nib = 4'hf;
            endcase
            if (brk >= 0 && i >= brk) nib = 4'h0;
        end
    endtask

    task automatic rd_chk(input logic [3:0] sel, input logic [27:0] a,
        input logic [7:0] exp, input string msg);
        logic [15:0] r;
        int          f;
        cyc_run(4'hd, sel, a, 4'h0, 8'h00, -1, -1, r, f);
        chk(f == 12 && r === {4'h0, exp[3:0], exp[7:4], 4'hf}, msg);
    endtask

    task automatic rd_get(input logic [27:0] a, output logic [7:0] d);
        logic [15:0] r;
        int          f;
        cyc_run(4'hd, 4'h0, a, 4'h0, 8'h00, -1, -1, r, f);
        d = {r[7:4], r[11:8]};
    endtask

    task automatic wr_chk(input logic [27:0] a, input logic [7:0] wd,
        input logic p, input string msg);
        logic [15:0] r;
        int          f;
        cyc_run(4'he, 4'h0, a, 4'h0, wd, -1, -1, r, f);
        chk(f == 14 && r[15:8] === 8'h0f, msg);
        if (a[22]) chk(last_wr === {p, wd, a[19:0]}, msg);
    endtask

    task automatic t_route();
        logic [7:0] n0;
        n0 = n_rd;
        rd_chk(4'h0, 28'hac51234, 8'h08, "core read");
        chk(caddr === 20'h51234, "low 20 address bits");
        rd_chk(4'h0, 28'hab50004, 8'h00, "unused reg");
        rd_chk(4'h0, 28'hab50002, 8'h01, "lock reset");
        chk(n_rd === n0 + 8'h01, "register read hit core");
        rd_chk(4'h0, 28'hac01234, 8'h00, "low range zero");
        $display("t_route done");
    endtask

    task automatic t_size();
        logic [15:0] r;
        int          f;
        logic [7:0]  n0, w0;
        logic [3:0]  sz[3] = '{4'h1, 4'h8, 4'hf};
        n0 = n_rd;
        w0 = n_wr;
        foreach (sz[j]) begin
            cyc_run(4'hd, 4'h0, 28'hac51234, sz[j], 8'h00, -1, -1, r, f);
            chk(f < 0, "bad size answered");
            cyc_run(4'he, 4'h0, 28'hac51234, sz[j], 8'h11, -1, -1, r, f);
            chk(f < 0, "bad size write answered");
        end
        chk(n_rd === n0 && n_wr === w0, "bad size reached core");
        rd_chk(4'h0, 28'hac51234, 8'h08, "read after bad size");
        $display("t_size done");
    endtask

    task automatic t_select();
        logic [15:0] r;
        int          f;
        strap = 4'h3;
        settle();
        cyc_run(4'hd, 4'h0, 28'hac51234, 4'h0, 8'h00, -1, -1, r, f);
        chk(f < 0, "foreign select answered");
        rd_chk(4'h3, 28'hac51201, 8'h3d, "own select");
        strap = 4'h0;
        settle();
        $display("t_select done");
    endtask

    task automatic t_abort_frame();
        logic [15:0] r;
        int          f;
        cyc_run(4'hd, 4'h0, 28'hac51234, 4'h0, 8'h00, 4, -1, r, f);
        chk(f < 0, "aborted cycle answered");
        cyc_run(4'hd, 4'h0, 28'hac51234, 4'h0, 8'h00, -1, -1, r, f);
        chk(f < 0, "start taken before 1111");
        rd_chk(4'h0, 28'hac51234, 8'h08, "read after abort");
        $display("t_abort_frame done");
    endtask

    task automatic t_protect();
        wr_chk(28'hac51000, 8'h30, 1'b1, "lock bit set");
        wr_chk(28'hab50002, 8'h00, 1'b0, "unlock 5");
        wr_chk(28'hac51000, 8'hff, 1'b0, "unlocked cmd");
        wp_n = 1'b0;
        settle();
        wr_chk(28'hac51000, 8'h20, 1'b1, "protect pin");
        rd_chk(4'h0, 28'hab50002, 8'h00, "pin not in lock");
        wp_n = 1'b1;
        wr_chk(28'habf0002, 8'h00, 1'b0, "unlock boot");
        tbl_n = 1'b0;
        settle();
        rd_chk(4'h0, 28'habf0002, 8'h00, "boot readback");
        wr_chk(28'hacf0010, 8'h55, 1'b1, "boot pin lock");
        wr_chk(28'hace0010, 8'h55, 1'b1, "block e not boot");
        wr_chk(28'hac50010, 8'h56, 1'b0, "pins independent");
        tbl_n = 1'b1;
        settle();
        wr_chk(28'hacf0010, 8'h57, 1'b0, "boot open");
        $display("t_protect done");
    endtask

    task automatic t_poll();
        logic [7:0]  d0, d1;
        logic [15:0] r;
        int          f;
        wr_chk(28'hac51234, 8'h5a, 1'b0, "poll byte");
        busy_cmd = 1'b1;
        rd_get(28'hac51234, d0);
        chk(d0[7] === 1'b1, "program poll bit");
        rd_get(28'hac51234, d1);
        chk(d1[6] === ~d0[6], "toggle in program");
        erase_cmd = 1'b1;
        rd_get(28'hac51234, d0);
        chk(d0[7] === 1'b0 && d0[6] === ~d1[6], "erase poll");
        rd_chk(4'h0, 28'hab50002, 8'h00, "reg read busy");
        cyc_run(4'he, 4'h0, 28'hab50002, 4'h0, 8'h01, -1, -1, r, f);
        busy_cmd = 1'b0;
        erase_cmd = 1'b0;
        rd_chk(4'h0, 28'hab50002, 8'h00, "reg write busy");
        rd_chk(4'h0, 28'hac51234, 8'h08, "true data");
        rd_chk(4'h0, 28'hac51234, 8'h08, "toggle ceased");
        $display("t_poll done");
    endtask

    task automatic t_reset();
        logic [15:0] r;
        int          f, n;
        logic [7:0]  a0;
        a0 = n_abort;
        busy_cmd = 1'b1;
        @(negedge clk_sys);
        init_n = 1'b0;
        n = 0;
        while (n_abort === a0 && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        chk(n >= 50 && n <= 58, "abort latency");
        repeat (4) @(negedge clk_sys);
        chk(n_abort === a0 + 8'h01, "one abort");
        init_n = 1'b1;
        busy_cmd = 1'b0;
        settle();
        rd_chk(4'h0, 28'hab50002, 8'h01, "init relocks");
        wr_chk(28'hab50002, 8'h00, 1'b0, "unlock 5");
        rpin_n = 1'b0;
        settle();
        rpin_n = 1'b1;
        settle();
        rd_chk(4'h0, 28'hab50002, 8'h01, "reset pin relocks");
        cyc_run(4'hd, 4'h0, 28'hac51234, 4'h0, 8'h00, -1, 6, r, f);
        chk(f < 0 && bus_oe === 1'b0, "reset in read");
        init_n = 1'b1;
        settle();
        rd_chk(4'h0, 28'hac51234, 8'h08, "read after reset");
        $display("t_reset done");
    endtask

    initial begin
        repeat (3) @(negedge clk_sys);
        rst_b = 1'b1;
        repeat (4) @(negedge clk_sys);
        t_route();
        t_size();
        t_select();
        t_abort_frame();
        t_protect();
        t_poll();
        t_reset();
        print_verdict();
    end
endmodule
`default_nettype wire
